// >>> mode_decode.sv
`timescale 1ns/1ns
module mode_decode
	import opmode_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input mode_pins_t mode_pins_i,
	output logic [2:0] pins_o,
	output op_mode_t mode_o,
	output mode_flags_t flags_o
);

	// sampled strap levels
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pins_o <= PINS_RST;
		end else begin
			pins_o <= mode_pins_i;
		end
	end

	// (RULE1) mode from pin value
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode_o <= OPM_UNSUPPORTED;
		end else begin
			mode_o <= decode_mode(pins_o);
		end
	end

	// (RULE2) one flag per mode
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flags_o <= '{boot: 1'b0, emulation: 1'b0, user_boot: 1'b0, advanced: 1'b0, unsupported: 1'b1};
		end else begin
			flags_o <= flags_of(decode_mode(pins_o));
		end
	end

endmodule

// >>> operating_mode_select.sv
// What this block does
// (RULE1) mode number is pins 2,1,0 read as binary, msb first
// (RULE2) mode 7 selects advanced mode, rom on, extended optional
// (RULE3) mode 1 is plain boot, mode 5 is user boot, for flash
// (RULE4) mode 3 selects on-chip emulation driving the jtag port
// (RULE5) board never straps modes 0, 2, 4 or 6
// (RULE6) board straps mode 7 for normal program execution
// (RULE7) board keeps mode pins stable while running
// (RULE8) after reset in mode 7 single-chip mode, extended enable is 0
// (RULE9) writing 1 to bit 7 switches to extended mode, 0 single-chip
// (RULE10) bits 2..0 report mode pins 2..0, same index
// (RULE11) status bits are read-only, writes do not touch them
// (RULE12) a read latches pin levels into status, reset cancels latches
// (RULE13) bits 6..3 read as 0 and ignore writes
`timescale 1ns/1ns
module operating_mode_select
	import opmode_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input mode_pins_t mode_pins_i,
	output op_mode_t mode_o,
	output mode_flags_t mode_flags_o,
	output logic [2:0] mode_status_o,
	output logic extended_mode_o,
	output logic single_chip_o
);

	logic [2:0] pins;
	logic ext_en;
	logic next_ext_en;
	logic status_valid;
	logic wr_pend;
	logic take;
	logic hit;
	logic rd_take;
	logic wr_take;
	logic wr_commit;
	mode_ctrl_t view;

	mode_decode u_decode (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.mode_pins_i(mode_pins_i),
		.pins_o(pins),
		.mode_o(mode_o),
		.flags_o(mode_flags_o)
	);

	// address phase qualification
	always_comb begin
		take = hsel_i && hready_i && hsize_i == HSIZE_WORD
			&& (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);
		if (haddr_i[11:0] == MODE_CTRL_OFFS && haddr_i[31:12] == 20'h0_0000) begin
			hit = 1'b1;
		end else begin
			hit = 1'b0;
		end
		rd_take = take && !hwrite_i && hit;
		wr_take = take && hwrite_i && hit;
		wr_commit = wr_pend;
	end

	// write data phase pending
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_pend <= 1'b0;
		end else begin
			wr_pend <= wr_take;
		end
	end

	// (RULE9) bit 7 write, forwarded to reads
	always_comb begin
		next_ext_en = ext_en;
		if (wr_commit) begin
			next_ext_en = hwdata_i[EXT_EN_BIT];
		end
	end

	// (RULE8) enable clears at reset
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ext_en <= EXT_EN_RST;
		end else begin
			ext_en <= next_ext_en;
		end
	end

	// (RULE10) register view of pins
	always_comb begin
		view = '0;
		view.extended_mode_enable = next_ext_en;
		// (RULE13) reserved read zero
		view.reserved = RESV_VALUE;
		view.mode_status_2 = pins[2];
		view.mode_status_1 = pins[1];
		view.mode_status_0 = pins[0];
	end

	// read data for the data phase
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hrdata_o <= RDATA_RST;
		end else if (take && !hwrite_i) begin
			if (hit) begin
				hrdata_o <= {RDATA_UPPER, view};
			end else begin
				hrdata_o <= RDATA_RST;
			end
		end
	end

	// zero wait states, always okay
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hreadyout_o <= 1'b1;
			hresp_o <= HRESP_OKAY;
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o <= HRESP_OKAY;
		end
	end

	// (RULE12) latch pins on read
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			status_valid <= 1'b0;
		end else if (rd_take) begin
			status_valid <= 1'b1;
		end
	end

	// (RULE11) only pins load status
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode_status_o <= STATUS_RST;
		end else if (rd_take || !status_valid) begin
			mode_status_o <= pins;
		end
	end

	// (RULE2) extended only in mode 7
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			extended_mode_o <= 1'b0;
			single_chip_o <= 1'b0;
		end else begin
			extended_mode_o <= next_ext_en && decode_mode(pins) == OPM_ADVANCED;
			single_chip_o <= !next_ext_en && decode_mode(pins) == OPM_ADVANCED;
		end
	end

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);

	AST_MODE_NUMBER: // (RULE1)
	assert property (
		$past(nrst_i) |=> mode_o == decode_mode($past(pins))
	) else $error("mode does not follow pin value");

	AST_ADVANCED_FLAG: // (RULE2)
	assert property (
		pins == MODE_ADVANCED ##1 pins == MODE_ADVANCED |=> mode_flags_o.advanced && !mode_flags_o.boot
	) else $error("mode 7 not advanced");

	AST_BOOT_FLAGS: // (RULE3)
	assert property (
		(pins == MODE_BOOT |=> mode_flags_o.boot && !mode_flags_o.user_boot)
		and (pins == MODE_USER_BOOT |=> mode_flags_o.user_boot && !mode_flags_o.boot)
	) else $error("boot mode flags wrong");

	AST_EMULATION_FLAG: // (RULE4)
	assert property (
		pins == MODE_EMULATION |=> mode_flags_o.emulation && !mode_flags_o.advanced
	) else $error("mode 3 not emulation");

	AST_SINGLE_CHIP: // (RULE8)
	assert property (
		!ext_en && !wr_commit && pins == MODE_ADVANCED |=> single_chip_o && !extended_mode_o
	) else $error("mode 7 without enable not single-chip");

	AST_EXT_ENABLE_SET: // (RULE9)
	assert property (
		wr_commit |=> ext_en == $past(hwdata_i[EXT_EN_BIT])
	) else $error("extended enable not written");

	AST_EXT_ENABLE_HOLD: // (RULE9)
	assert property (
		!wr_commit |=> $stable(ext_en)
	) else $error("extended enable changed without write");

	AST_STATUS_READBACK: // (RULE10)
	assert property (
		rd_take |=> hrdata_o[STATUS_MSB:STATUS_LSB] == $past(pins)
			&& hrdata_o[EXT_EN_BIT] == ext_en
	) else $error("read data does not show pins and enable");

	AST_STATUS_READONLY: // (RULE11)
	assert property (
		status_valid && !rd_take |=> $stable(mode_status_o)
	) else $error("status changed without a read");

	AST_STATUS_LATCH: // (RULE12)
	assert property (
		rd_take |=> status_valid && mode_status_o == $past(pins)
	) else $error("read did not latch pins");

	AST_RESERVED_ZERO: // (RULE13)
	assert property (
		take && !hwrite_i |=> hrdata_o[31:8] == RDATA_UPPER
			&& hrdata_o[RESV_MSB:RESV_LSB] == RESV_VALUE
	) else $error("reserved bits not zero");

	AST_BUS_OKAY:
	assert property (
		hreadyout_o && hresp_o == HRESP_OKAY
	) else $error("bus answer not ready okay");

	AST_FLAGS_ONEHOT: // (RULE1)
	assert property (
		$onehot(mode_flags_o)
	) else $error("mode flags not one-hot");

	AST_FLAGS_MATCH_MODE: // (RULE1)
	assert property (
		mode_flags_o == flags_of(mode_o)
	) else $error("mode flags disagree with mode");

	AST_UNSUPPORTED_FLAG: // (RULE1)
	assert property (
		!pins[0] |=> mode_flags_o.unsupported && mode_o == OPM_UNSUPPORTED
	) else $error("even pin value not unsupported");

	AST_ADVANCED_MODE: // (RULE2)
	assert property (
		pins == MODE_ADVANCED |=> mode_o == OPM_ADVANCED
	) else $error("mode 7 not decoded");

	AST_EXT_ONLY_ADVANCED: // (RULE2)
	assert property (
		decode_mode(pins) != OPM_ADVANCED |=> !extended_mode_o && !single_chip_o
	) else $error("chip mode outside mode 7");

	AST_BOOT_MODE: // (RULE3)
	assert property (
		pins == MODE_BOOT |=> mode_o == OPM_BOOT
	) else $error("mode 1 not boot");

	AST_USER_BOOT_MODE: // (RULE3)
	assert property (
		pins == MODE_USER_BOOT |=> mode_o == OPM_USER_BOOT
	) else $error("mode 5 not user boot");

	AST_EMULATION_MODE: // (RULE4)
	assert property (
		pins == MODE_EMULATION |=> mode_o == OPM_EMULATION
	) else $error("mode 3 not decoded");

	AST_EXT_MODE_ON: // (RULE9)
	assert property (
		ext_en && !wr_commit && pins == MODE_ADVANCED |=> extended_mode_o && !single_chip_o
	) else $error("mode 7 with enable not extended");

	AST_CHIP_MODES_EXCLUSIVE: // (RULE9)
	assert property (
		!(extended_mode_o && single_chip_o)
	) else $error("single-chip and extended both set");

	AST_RDATA_HOLD: // (RULE10)
	assert property (
		!(take && !hwrite_i) |=> $stable(hrdata_o)
	) else $error("read data changed without a read");

	AST_WRITE_KEEPS_STATUS: // (RULE11)
	assert property (
		status_valid && wr_commit && !rd_take |=> $stable(mode_status_o)
	) else $error("write changed status");

	AST_STATUS_FOLLOWS: // (RULE12)
	assert property (
		!status_valid |=> mode_status_o == $past(pins)
	) else $error("status not following pins before first read");

	AST_UNMAPPED_READ_ZERO: // (RULE13)
	assert property (
		take && !hwrite_i && !hit |=> hrdata_o == RDATA_RST
	) else $error("unmapped read not zero");

	COV_READ: cover property (rd_take ##1 status_valid);
	COV_EXT_ON: cover property (wr_commit && hwdata_i[EXT_EN_BIT] ##1 extended_mode_o);
	COV_BOOT: cover property (mode_flags_o.user_boot ##1 rd_take);
	COV_WRITE_THEN_READ: cover property (wr_take ##1 rd_take);
	COV_UNSUPPORTED: cover property (mode_flags_o.unsupported ##1 rd_take);

endmodule

// >>> operating_mode_select_tb.sv
`timescale 1ns/1ns
module operating_mode_select_tb;
	import opmode_pkg::*;
	logic core_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [31:0] haddr_i = 32'h0000_0000;
	logic [1:0] htrans_i = 2'h0;
	logic hwrite_i = 1'b0;
	logic [31:0] hwdata_i = 32'h0000_0000;
	logic [31:0] hrdata_o, rd;
	logic hreadyout_o, hresp_o, extended_mode_o, single_chip_o;
	mode_pins_t pins;
	op_mode_t mode_o, e;
	mode_flags_t mode_flags_o, fexp;
	logic [2:0] mode_status_o, p;
	logic [2:0] strap = 3'h7;
	logic hot = 1'b0;
	int err_count = 0;
	int checks = 0;
	int cycles = 0;
	localparam logic [5:0] ROWS [8] = '{{3'h0, OPM_UNSUPPORTED}, {3'h1, OPM_BOOT}, {3'h2, OPM_UNSUPPORTED},
		{3'h3, OPM_EMULATION}, {3'h4, OPM_UNSUPPORTED}, {3'h5, OPM_USER_BOOT}, {3'h6, OPM_UNSUPPORTED},
		{3'h7, OPM_ADVANCED}};
	always #50 core_clk_i = ~core_clk_i;
	strap_model strap_model_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .strap_i(strap), .hot_i(hot),
		.mode_pins_o(pins));
	operating_mode_select operating_mode_select_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .hsel_i(1'b1),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(HSIZE_WORD),
		.hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o), .mode_pins_i(pins), .mode_o(mode_o), .mode_flags_o(mode_flags_o),
		.mode_status_o(mode_status_o), .extended_mode_o(extended_mode_o), .single_chip_o(single_chip_o));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge core_clk_i);
		haddr_i <= a;
		htrans_i <= HTRANS_NONSEQ;
		hwrite_i <= w;
		do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
		chk({hreadyout_o, hresp_o}, 2);
	endtask
	task rst(input logic [2:0] s);
		@(posedge core_clk_i);
		strap <= s;
		nrst_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
	endtask
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			close_out();
		end
	end
	initial begin
		repeat (15) @(posedge core_clk_i);
		chk(extended_mode_o, 0);
		chk(mode_status_o, 0);
		chk({hreadyout_o, hresp_o}, 2);
		@(posedge core_clk_i);
		nrst_i <= 1'b1;
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			rst(ROWS[i][5:3]);
			p = ROWS[i][5:3];
			e = op_mode_t'(ROWS[i][2:0]);
			fexp = '{e == OPM_BOOT, e == OPM_EMULATION, e == OPM_USER_BOOT, e == OPM_ADVANCED, e == OPM_UNSUPPORTED};
			chk(mode_o, e);
			chk(mode_flags_o, fexp);
			chk(mode_status_o, p);
			chk(single_chip_o, p == 3'h7);
			bus(1'b0, 32'h0, 32'h0);
			chk(rd, {29'h0, p});
		end
		$display("test table done");
		bus(1'b1, 32'h0, 32'hffff_ffff);
		bus(1'b0, 32'h0, 32'h0);
		chk(rd, 32'h87);
		chk({extended_mode_o, single_chip_o}, 2);
		bus(1'b1, 32'h0, 32'h0);
		bus(1'b0, 32'h0, 32'h0);
		chk(rd, 32'h07);
		chk({extended_mode_o, single_chip_o}, 1);
		$display("test extend done");
		bus(1'b1, 32'h0, 32'h80);
		@(posedge core_clk_i);
		strap <= 3'h5;
		hot <= 1'b1;
		@(posedge core_clk_i);
		hot <= 1'b0;
		repeat (4) @(posedge core_clk_i);
		chk(mode_status_o, 7);
		chk(mode_o, OPM_USER_BOOT);
		bus(1'b0, 32'h0, 32'h0);
		chk(rd, 32'h85);
		chk(mode_status_o, 5);
		$display("test latch done");
		rst(3'h1);
		bus(1'b0, 32'h0, 32'h0);
		chk(rd, 32'h01);
		bus(1'b1, 32'h0, 32'hff);
		bus(1'b0, 32'h0, 32'h0);
		chk(rd, 32'h81);
		chk(extended_mode_o, 0);
		bus(1'b1, 32'h4, 32'h0);
		bus(1'b0, 32'h4, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 32'h0, 32'h0);
		chk(rd, 32'h81);
		$display("test refuse done");
		close_out();
	end
endmodule

// >>> opmode_pkg.sv
package opmode_pkg;

	// register map
	localparam logic [11:0] MODE_CTRL_OFFS = 12'h000;
	localparam int EXT_EN_BIT = 7;
	localparam int RESV_MSB = 6;
	localparam int RESV_LSB = 3;
	localparam int STATUS_MSB = 2;
	localparam int STATUS_LSB = 0;
	localparam logic EXT_EN_RST = 1'b0;
	localparam logic [3:0] RESV_VALUE = 4'h0;
	localparam logic [2:0] STATUS_RST = 3'h0;
	localparam logic [2:0] PINS_RST = 3'h0;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;
	localparam logic [23:0] RDATA_UPPER = 24'h00_0000;

	// mode numbers on the strap pins
	localparam logic [2:0] MODE_BOOT = 3'h1;
	localparam logic [2:0] MODE_EMULATION = 3'h3;
	localparam logic [2:0] MODE_USER_BOOT = 3'h5;
	localparam logic [2:0] MODE_ADVANCED = 3'h7;

	// ahb-lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [2:0] {
		OPM_UNSUPPORTED,
		OPM_BOOT,
		OPM_EMULATION,
		OPM_USER_BOOT,
		OPM_ADVANCED
	} op_mode_t;

	typedef struct packed {
		logic mode_pin_2;
		logic mode_pin_1;
		logic mode_pin_0;
	} mode_pins_t;

	typedef struct packed {
		logic boot;
		logic emulation;
		logic user_boot;
		logic advanced;
		logic unsupported;
	} mode_flags_t;

	typedef struct packed {
		logic extended_mode_enable;
		logic [3:0] reserved;
		logic mode_status_2;
		logic mode_status_1;
		logic mode_status_0;
	} mode_ctrl_t;

	// pin value, msb first, to mode
	function automatic op_mode_t decode_mode(input logic [2:0] pins);
		op_mode_t m;
		m = OPM_UNSUPPORTED;
		// (RULE3) boot modes 1 and 5
		// (RULE4) emulation in mode 3
		if (pins == MODE_BOOT) begin
			m = OPM_BOOT;
		end else if (pins == MODE_EMULATION) begin
			m = OPM_EMULATION;
		end else if (pins == MODE_USER_BOOT) begin
			m = OPM_USER_BOOT;
		end else if (pins == MODE_ADVANCED) begin
			m = OPM_ADVANCED;
		end
		return m;
	endfunction

	function automatic mode_flags_t flags_of(input op_mode_t m);
		mode_flags_t f;
		f = '0;
		f.boot = (m == OPM_BOOT);
		f.emulation = (m == OPM_EMULATION);
		f.user_boot = (m == OPM_USER_BOOT);
		f.advanced = (m == OPM_ADVANCED);
		f.unsupported = (m == OPM_UNSUPPORTED);
		return f;
	endfunction

endpackage

// >>> strap_model.sv
`timescale 1ns/1ns
module strap_model
	import opmode_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic [2:0] strap_i,
	input wire logic hot_i,
	output mode_pins_t mode_pins_o
);
	initial mode_pins_o = '0;
	always @(posedge core_clk_i) begin
		if (!nrst_i || hot_i) begin
			mode_pins_o <= strap_i;
		end
	end
endmodule
